// [src/high_side_driver_unit_top.sv]
// high-side driver control with ahb-lite register slave
`timescale 1ns/100ps
`default_nettype none
module high_side_driver_unit_top
    import high_side_driver_unit_pkg::*;
#(
    parameter int MASK_CYCLES = HIGH_SIDE_DRIVER_UNIT_MASK_CYCLES
)
(
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        clk_en_i,
    input  wire logic        hsel_i,
    input  wire logic [7:0]  haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        stop_mode_i,
    input  wire logic [1:0]  timer_in_i,
    input  wire logic [1:0]  oc_detect_i,
    output logic [1:0]       driver_output_o,
    output logic             supply_en_o,
    output logic             irq_o
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0]  data_q;
    logic [1:0]  en_q;
    logic [1:0]  ocme_q;
    logic        ocie_q;
    logic [1:0]  route_q;
    logic [1:0]  flag;
    logic [1:0]  drive;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [1:0]  flag_clr;

    function automatic logic [31:0] read_word(input logic [7:0] a);
        case (a)
            HIGH_SIDE_DRIVER_UNIT_DATA_ADDR:  read_word = {30'h0, data_q};
            HIGH_SIDE_DRIVER_UNIT_CTRL_ADDR:  read_word = {26'h0, ocme_q, 2'h0, en_q};
            HIGH_SIDE_DRIVER_UNIT_FLAG_ADDR:  read_word = {30'h0, flag};
            HIGH_SIDE_DRIVER_UNIT_IE_ADDR:    read_word = {31'h0, ocie_q};
            HIGH_SIDE_DRIVER_UNIT_ROUTE_ADDR: read_word = {30'h0, route_q};
            default:          read_word = 32'h0;
        endcase
    endfunction : read_word

    // ------------------------------------------------------------
    // bus slave: zero wait states, always okay
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_o  <= 32'h0;
        end
        else if (clk_en_i)
        begin
            wr_pend_q <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
            wr_addr_q <= {haddr_i[7:2], 2'b00};
            if (hsel_i && hready_i && htrans_i[1] && !hwrite_i)
                hrdata_o <= read_word({haddr_i[7:2], 2'b00});
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
        else
        begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // writable fields
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            data_q  <= HIGH_SIDE_DRIVER_UNIT_RST_2B;
            en_q    <= HIGH_SIDE_DRIVER_UNIT_RST_2B;
            ocme_q  <= HIGH_SIDE_DRIVER_UNIT_RST_2B;
            ocie_q  <= 1'b0;
            route_q <= HIGH_SIDE_DRIVER_UNIT_RST_2B;
        end
        else if (clk_en_i && wr_pend_q)
        begin
            case (wr_addr_q)
                HIGH_SIDE_DRIVER_UNIT_DATA_ADDR:  data_q <= hwdata_i[1:0];
                HIGH_SIDE_DRIVER_UNIT_CTRL_ADDR:
                begin
                    en_q <= hwdata_i[HIGH_SIDE_DRIVER_UNIT_EN_POS +: 2];
                    for (int i = 0; i < 2; i++)
                        if (!en_q[i])
                            ocme_q[i] <= hwdata_i[HIGH_SIDE_DRIVER_UNIT_OCME_POS + i];
                end
                HIGH_SIDE_DRIVER_UNIT_IE_ADDR:    ocie_q <= hwdata_i[HIGH_SIDE_DRIVER_UNIT_OCIE_POS];
                HIGH_SIDE_DRIVER_UNIT_ROUTE_ADDR: route_q <= hwdata_i[1:0];
                default:          ;
            endcase
        end
    end

    assign flag_clr = (wr_pend_q && wr_addr_q == HIGH_SIDE_DRIVER_UNIT_FLAG_ADDR) ? hwdata_i[1:0] : 2'b00;

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    generate
        for (genvar c = 0; c < 2; c++)
        begin : g_ch
            high_side_driver_unit_channel #(
                .MASK_CYCLES (MASK_CYCLES)
            ) u_ch (
                .core_clk_i  (core_clk_i),
                .nrst_i      (nrst_i),
                .clk_en_i    (clk_en_i),
                .enable_i    (en_q[c]),
                .mask_en_i   (ocme_q[c]),
                .route_sel_i (route_q[c]),
                .data_bit_i  (data_q[c]),
                .timer_in_i  (timer_in_i[c]),
                .oc_detect_i (oc_detect_i[c]),
                .flag_clr_i  (flag_clr[c]),
                .drive_o     (drive[c]),
                .flag_o      (flag[c])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            driver_output_o <= 2'b00;
            supply_en_o     <= 1'b0;
            irq_o           <= 1'b0;
        end
        else if (clk_en_i)
        begin
            driver_output_o <= drive & ~flag;
            supply_en_o     <= |en_q;
            irq_o           <= (|flag) & ocie_q & ~stop_mode_i;
        end
    end
endmodule : high_side_driver_unit_top
`default_nettype wire

// [src/high_side_driver_unit_pkg.sv]
// constants for the high-side driver control block
//
// Behaviour
// - two driver channels, each switched by a data bit or a routed timer/PWM input.
// - both driver outputs and the driver supply path are off after reset.
// - an over-current report of a channel sets that channel's own flag.
// - while a channel's flag is set its driver is forced off.
// - clearing the flag returns the driver to its routed control source.
// - with mask bit set, over-current is ignored for a fixed time after switch-on.
// - mask bit is writable only while that channel's enable bit is zero.
// - interrupt requested when any flag is set and interrupt enable is one.
// - interrupt is issued only in run mode, never in stop mode.
// - entering or leaving stop mode neither sets nor clears any flag.
package high_side_driver_unit_pkg;
    // ------------------------------------------------------------
    // register indices and byte addresses, one word per register
    // ------------------------------------------------------------
    localparam int         HIGH_SIDE_DRIVER_UNIT_DATA_IDX    = 0;
    localparam int         HIGH_SIDE_DRIVER_UNIT_CTRL_IDX    = 1;
    localparam int         HIGH_SIDE_DRIVER_UNIT_RSVD_IDX    = 2;
    localparam logic [7:0] HIGH_SIDE_DRIVER_UNIT_DATA_ADDR   = 8'(HIGH_SIDE_DRIVER_UNIT_DATA_IDX * 4);
    localparam logic [7:0] HIGH_SIDE_DRIVER_UNIT_CTRL_ADDR   = 8'(HIGH_SIDE_DRIVER_UNIT_CTRL_IDX * 4);
    localparam logic [7:0] HIGH_SIDE_DRIVER_UNIT_RSVD_ADDR   = 8'(HIGH_SIDE_DRIVER_UNIT_RSVD_IDX * 4);
    localparam logic [7:0] HIGH_SIDE_DRIVER_UNIT_FLAG_ADDR   = 8'h0C;
    localparam logic [7:0] HIGH_SIDE_DRIVER_UNIT_IE_ADDR     = 8'h10;
    localparam logic [7:0] HIGH_SIDE_DRIVER_UNIT_ROUTE_ADDR  = 8'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int HIGH_SIDE_DRIVER_UNIT_EN_POS    = 0;
    localparam int HIGH_SIDE_DRIVER_UNIT_OCME_POS  = 4;
    localparam int HIGH_SIDE_DRIVER_UNIT_OCIE_POS  = 0;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [1:0] HIGH_SIDE_DRIVER_UNIT_RST_2B = 2'h0;
    localparam int HIGH_SIDE_DRIVER_UNIT_CLK_MHZ        = 40;
    localparam int HIGH_SIDE_DRIVER_UNIT_MASK_TIME_NS   = 1000;
    localparam int HIGH_SIDE_DRIVER_UNIT_MASK_CYCLES    = (HIGH_SIDE_DRIVER_UNIT_MASK_TIME_NS * HIGH_SIDE_DRIVER_UNIT_CLK_MHZ + 999) / 1000;
    localparam int HIGH_SIDE_DRIVER_UNIT_CNT_W          = 16;
endpackage : high_side_driver_unit_pkg

// [src/high_side_driver_unit_channel.sv]
// one driver channel: source select, masking window, over-current latch
`timescale 1ns/100ps
`default_nettype none
module high_side_driver_unit_channel
    import high_side_driver_unit_pkg::*;
#(
    parameter int MASK_CYCLES = HIGH_SIDE_DRIVER_UNIT_MASK_CYCLES
)
(
    input  wire logic core_clk_i,
    input  wire logic nrst_i,
    input  wire logic clk_en_i,
    input  wire logic enable_i,
    input  wire logic mask_en_i,
    input  wire logic route_sel_i,
    input  wire logic data_bit_i,
    input  wire logic timer_in_i,
    input  wire logic oc_detect_i,
    input  wire logic flag_clr_i,
    output logic      drive_o,
    output logic      flag_o
);
    logic                   request;
    logic                   drive_q;
    logic [HIGH_SIDE_DRIVER_UNIT_CNT_W-1:0] mask_cnt_q;
    logic                   masked;

    assign request = enable_i & (route_sel_i ? timer_in_i : data_bit_i);
    assign masked  = mask_en_i && (mask_cnt_q != '0);

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            drive_q <= 1'b0;
        else if (clk_en_i)
            drive_q <= request & ~flag_o;
    end

    // window restarts on each off-to-on switch
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            mask_cnt_q <= '0;
        else if (clk_en_i)
        begin
            if (!drive_q)
                mask_cnt_q <= HIGH_SIDE_DRIVER_UNIT_CNT_W'(MASK_CYCLES);
            else if (mask_cnt_q != '0)
                mask_cnt_q <= mask_cnt_q - 1'b1;
        end
    end

    // set wins over clear; stop mode does not touch it
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            flag_o <= 1'b0;
        else if (clk_en_i)
        begin
            if (oc_detect_i && drive_q && !masked)
                flag_o <= 1'b1;
            else if (flag_clr_i)
                flag_o <= 1'b0;
        end
    end

    assign drive_o = drive_q;
endmodule : high_side_driver_unit_channel
`default_nettype wire

// [sim/hsdc_assertions.sv]
// port-level checks for the high-side driver control block
`timescale 1ns/100ps
`default_nettype none
module hsdc_assertions
    import high_side_driver_unit_pkg::*;
#(
    parameter int MASK_CYCLES = HIGH_SIDE_DRIVER_UNIT_MASK_CYCLES
)
(
    input wire logic        core_clk_i,
    input wire logic        nrst_i,
    input wire logic        clk_en_i,
    input wire logic        hsel_i,
    input wire logic [7:0]  haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic        stop_mode_i,
    input wire logic [1:0]  oc_detect_i,
    input wire logic [1:0]  driver_output_o,
    input wire logic        supply_en_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    wire logic rd_go = hsel_i && hready_i && htrans_i[1] && !hwrite_i && clk_en_i;
    sequence empty_rd;
        rd_go && ({haddr_i[7:2], 2'b00} == HIGH_SIDE_DRIVER_UNIT_RSVD_ADDR || {haddr_i[7:2], 2'b00} > HIGH_SIDE_DRIVER_UNIT_ROUTE_ADDR);
    endsequence
    a_ready_high: assert property (hreadyout_o) else $error("ready low");
    a_resp_okay: assert property (!hresp_o) else $error("error response");
    a_stop_irq_quiet: assert property ($past(stop_mode_i && clk_en_i) |-> !irq_o) else $error("irq in stop");
    a_empty_reads_zero: assert property (empty_rd |=> hrdata_o == 32'h0) else $error("nonzero read");
    a_rdata_holds: assert property (!$past(rd_go) |-> $stable(hrdata_o)) else $error("read data moved");
    a_freeze_outputs: assert property (!$past(clk_en_i) |-> $stable({driver_output_o, irq_o})) else $error("moved");
    a_drive_has_supply: assert property (driver_output_o != 2'h0 |-> $past(supply_en_o)) else $error("no supply");
    for (genvar i = 0; i < 2; i++)
    begin : g_ch
        // cycles the driver has been on; past the mask window plus margin
        logic [7:0] on_q;
        always_ff @(posedge core_clk_i or negedge nrst_i)
        begin
            if (!nrst_i)
                on_q <= 8'h0;
            else if (!driver_output_o[i])
                on_q <= 8'h0;
            else if (on_q != 8'hFF)
                on_q <= on_q + 8'h1;
        end
        a_oc_cuts_drive: assert property (on_q > MASK_CYCLES + 2 && oc_detect_i[i] && clk_en_i
            |-> ##[1:4] !driver_output_o[i]) else $error("no shutdown");
    end
endmodule : hsdc_assertions
bind high_side_driver_unit_top hsdc_assertions #(.MASK_CYCLES(MASK_CYCLES)) u_chk (.core_clk_i, .nrst_i, .clk_en_i, .hsel_i,
    .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .stop_mode_i, .oc_detect_i,
    .driver_output_o, .supply_en_o, .irq_o);
`default_nettype wire

// [sim/hsdc_load_model.sv]
// driver stages with a commanded load short
`timescale 1ns/100ps
`default_nettype none
module hsdc_load_model
(
    input  wire logic       core_clk_i,
    input  wire logic [1:0] drive_i,
    input  wire logic [1:0] short_i,
    output logic [1:0]      oc_detect_o = 2'h0
);
    // comparator sees current only while the stage conducts
    always @(posedge core_clk_i)
        oc_detect_o <= drive_i & short_i;
endmodule : hsdc_load_model
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the high-side driver control block
`timescale 1ns/100ps
`default_nettype none
module tb;
    typedef struct packed { logic [7:0] a, w, e; } hsdc_row_t;
    localparam int MC = 16;
    logic        core_clk_i = 1'h0, nrst_i = 1'h0, clk_en_i = 1'h1, hsel_i = 1'h0, hwrite_i = 1'h0;
    logic        stop_mode_i = 1'h0, hreadyout_o, hresp_o, supply_en_o, irq_o;
    logic [7:0]  haddr_i = 8'h0;
    logic [1:0]  htrans_i = 2'h0, timer_in_i = 2'h0, short_q = 2'h0, oc_detect_i, driver_output_o;
    logic [31:0] hwdata_i = 32'h0, hrdata_o, r;
    int          fails = 0, checked = 0;
    hsdc_row_t   rows [13] = '{'{8'h0C, 8'hFF, 8'h00}, '{8'h04, 8'h33, 8'h33}, '{8'h04, 8'h03, 8'h33},
        '{8'h04, 8'h00, 8'h30}, '{8'h04, 8'h00, 8'h00}, '{8'h08, 8'hFF, 8'h00}, '{8'h18, 8'hFF, 8'h00},
        '{8'h10, 8'hFF, 8'h01}, '{8'h10, 8'h00, 8'h00}, '{8'h14, 8'h03, 8'h03}, '{8'h14, 8'h00, 8'h00},
        '{8'h00, 8'hFF, 8'h03}, '{8'h00, 8'h03, 8'h03}};
    always #12.5 core_clk_i = ~core_clk_i;
    high_side_driver_unit_top #(.MASK_CYCLES(MC)) uut (.core_clk_i, .nrst_i, .clk_en_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .stop_mode_i,
        .timer_in_i, .oc_detect_i, .driver_output_o, .supply_en_o, .irq_o);
    hsdc_load_model u_load (.core_clk_i, .drive_i(driver_output_o), .short_i(short_q), .oc_detect_o(oc_detect_i));
    task automatic chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : tick
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        haddr_i <= a;
        hwrite_i <= w;
        htrans_i <= 2'h2;
        hsel_i <= 1'h1;
        do @(posedge core_clk_i); while (hreadyout_o !== 1'h1);
        htrans_i <= 2'h0;
        hwdata_i <= {24'h0, d};
        do @(posedge core_clk_i); while (hreadyout_o !== 1'h1);
        r = hrdata_o;
    endtask : bus
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize
    initial
    begin
        #500000;
        fails++;
        summarize();
    end
    initial
    begin
        tick(1);
        chk("reset outs", {driver_output_o, supply_en_o, irq_o}, 32'h0);
        tick(15);
        nrst_i <= 1'h1;
        bus(8'h04, 1'h0, 8'h0);
        chk("ctrl reset", r, 32'h0);
        foreach (rows[i])
        begin
            bus(rows[i].a, 1'h1, rows[i].w);
            bus(rows[i].a, 1'h0, 8'h0);
            chk("reg", r, {24'h0, rows[i].e});
        end
        // ---- source selection and clock-enable freeze ----
        bus(8'h04, 1'h1, 8'h03);
        tick(3);
        chk("drv", {supply_en_o, driver_output_o}, 32'h7);
        bus(8'h14, 1'h1, 8'h01);
        tick(3);
        chk("route", driver_output_o, 32'h2);
        timer_in_i <= 2'h1;
        tick(3);
        clk_en_i <= 1'h0;
        timer_in_i <= 2'h0;
        tick(4);
        chk("freeze", driver_output_o, 32'h3);
        clk_en_i <= 1'h1;
        tick(3);
        chk("timer", driver_output_o, 32'h2);
        bus(8'h14, 1'h1, 8'h00);
        // ---- shutdown, interrupt, stop mode, flag clear ----
        bus(8'h10, 1'h1, 8'h01);
        short_q <= 2'h1;
        tick(6);
        chk("shutdown", driver_output_o, 32'h2);
        bus(8'h0C, 1'h0, 8'h0);
        chk("flag", r, 32'h1);
        chk("irq", irq_o, 32'h1);
        stop_mode_i <= 1'h1;
        tick(2);
        chk("stop irq", irq_o, 32'h0);
        stop_mode_i <= 1'h0;
        bus(8'h0C, 1'h1, 8'h00);
        bus(8'h0C, 1'h0, 8'h0);
        chk("flag kept", {irq_o, r[30:0]}, 32'h80000001);
        bus(8'h10, 1'h1, 8'h00);
        tick(2);
        chk("irq masked", irq_o, 32'h0);
        bus(8'h10, 1'h1, 8'h01);
        short_q <= 2'h0;
        bus(8'h0C, 1'h1, 8'h01);
        tick(3);
        chk("returned", {irq_o, driver_output_o}, 32'h3);
        // ---- masking window after switch-on ----
        bus(8'h04, 1'h1, 8'h00);
        bus(8'h04, 1'h1, 8'h11);
        short_q <= 2'h1;
        tick(MC / 2);
        chk("masked", driver_output_o, 32'h1);
        tick(MC + 4);
        chk("late cut", driver_output_o, 32'h0);
        // ---- reset in mid-run ----
        bus(8'h04, 1'h1, 8'h03);
        short_q <= 2'h0;
        tick(4);
        nrst_i <= 1'h0;
        tick(2);
        chk("mid reset outs", {driver_output_o, supply_en_o, irq_o}, 32'h0);
        nrst_i <= 1'h1;
        bus(8'h04, 1'h0, 8'h0);
        chk("mid reset ctrl", r, 32'h0);
        bus(8'h0C, 1'h0, 8'h0);
        chk("mid reset flag", r, 32'h0);
        summarize();
    end
endmodule : tb
`default_nettype wire
